// file: logic/sbm_pkg.sv
// shared constants and types for the system bus master controller
`default_nettype none
package sbm_pkg;
  // clock period of the controller
  localparam int unsigned CLK_PERIOD_PS = 50000;
  // nominal bus clock, only for reference; neither the logic nor the bench uses it
  localparam int unsigned BUS_CLK_PERIOD_PS = 101725;
  // widths of the bus
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  // least spacing of command starts: 5 million bytes per second
  localparam int unsigned BYTE_PERIOD_PS = 200000;
  localparam int unsigned BYTE_CYCLES =
    (BYTE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // address and data settle time before a command
  localparam int unsigned ADDR_SETUP_PS = 50000;
  localparam int unsigned SETUP_CYCLES =
    (ADDR_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] BYTE_CNT = CNT_W'(BYTE_CYCLES - 1);
  localparam logic [CNT_W-1:0] SETUP_CNT = CNT_W'(SETUP_CYCLES);
  // reset values
  localparam logic [ADDR_W-1:0] ADDR_IDLE = 16'hffff;
  localparam logic [DATA_W-1:0] DATA_IDLE = 8'hff;

  typedef enum logic [1:0] {
    SBM_MEM_RD,
    SBM_MEM_WR,
    SBM_IO_RD,
    SBM_IO_WR
  } sbm_cmd_t;
endpackage
`default_nettype wire

// file: logic/sbm_sync_if.sv
// synchronised bus inputs passed from the synchroniser to the controller
`timescale 1ns/100ps
`default_nettype none
interface sbm_sync_if;
  logic bclk_n;
  logic init_n;
  logic granted_n;
  logic xack_n;
  logic aack_n;
  logic [7:0] dat_n;
  modport syncer (output bclk_n, init_n, granted_n, xack_n, aack_n, dat_n);
  modport ctrl (input bclk_n, init_n, granted_n, xack_n, aack_n, dat_n);
endinterface
`default_nettype wire

// file: logic/sbm_sync.sv
// two-flop synchronisers for every bus pin the controller reads
`timescale 1ns/100ps
`default_nettype none
module sbm_sync
  import sbm_pkg::*;
#(
  parameter int unsigned WIDTH = 13
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw pins
  input wire logic bclk_n,
  input wire logic init_n,
  input wire logic granted_n,
  input wire logic xack_n,
  input wire logic aack_n,
  input wire logic [sbm_pkg::DATA_W-1:0] dat_n,
  // synchronised copies
  sbm_sync_if.syncer sy
);
  import sbm_pkg::*;
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  wire [WIDTH-1:0] raw = {bclk_n, init_n, granted_n, xack_n, aack_n, dat_n};

  // pins idle high, so reset to the inactive level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= raw;
      sync_reg <= meta_reg;
    end
  end

  assign sy.bclk_n = sync_reg[12];
  assign sy.init_n = sync_reg[11];
  assign sy.granted_n = sync_reg[10];
  assign sy.xack_n = sync_reg[9];
  assign sy.aack_n = sync_reg[8];
  assign sy.dat_n = sync_reg[7:0];
endmodule
`default_nettype wire

// file: logic/sbm_master.sv
// external bus master: takes the bus from the board and runs transfers
`timescale 1ns/100ps
`default_nettype none
module sbm_master
  import sbm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // user request
  input wire logic req_valid,
  input wire sbm_pkg::sbm_cmd_t req_cmd,
  input wire logic [sbm_pkg::ADDR_W-1:0] req_addr,
  input wire logic [sbm_pkg::DATA_W-1:0] req_wdata,
  input wire logic req_last,
  output logic req_ready,
  // user answer
  output logic rsp_valid,
  output logic [sbm_pkg::DATA_W-1:0] rsp_rdata,
  output logic bus_owned,
  // bus inputs from the board and slaves
  input wire logic bclk_n,
  input wire logic init_n,
  input wire logic takeover_granted_n,
  input wire logic xack_n,
  input wire logic aack_n,
  input wire logic [sbm_pkg::DATA_W-1:0] dat_n_i,
  // bus outputs
  output logic hold_n,
  output logic [sbm_pkg::ADDR_W-1:0] adr_n_o,
  output logic adr_oe,
  output logic [sbm_pkg::DATA_W-1:0] dat_n_o,
  output logic dat_oe,
  output logic mrdc_n,
  output logic mwtc_n,
  output logic iorc_n,
  output logic iowc_n,
  output logic cmd_oe
);
  import sbm_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_REQ, S_OWN, S_SETUP, S_CMD, S_DONE} sbm_state_t;

  sbm_sync_if sy ();

  sbm_sync #(.WIDTH(13)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .bclk_n(bclk_n),
    .init_n(init_n),
    .granted_n(takeover_granted_n),
    .xack_n(xack_n),
    .aack_n(aack_n),
    .dat_n(dat_n_i),
    .sy(sy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state
  sbm_state_t state_reg, state_next;
  sbm_cmd_t cmd_reg;
  logic last_reg;
  logic bclk_d_reg;
  logic [CNT_W-1:0] setup_reg;
  logic [CNT_W-1:0] gap_reg;
  logic [ADDR_W-1:0] adr_n_reg;
  logic [DATA_W-1:0] dat_n_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [3:0] cmd_n_reg;
  logic hold_n_reg, adr_oe_reg, dat_oe_reg, rsp_reg, ready_reg;

  function automatic logic is_write(input sbm_cmd_t c);
    return (c == SBM_MEM_WR) || (c == SBM_IO_WR);
  endfunction

  // bus inactive level is high, so a low strobe is the active one
  function automatic logic [3:0] cmd_lines_n(input sbm_cmd_t c);
    logic [3:0] v;
    v = 4'hf;
    v[c] = 1'b0;
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire init_hit = !sy.init_n;
  // the board's bus clock rising edge (pin falling, active low)
  wire bclk_edge = bclk_d_reg && !sy.bclk_n;
  wire granted = !sy.granted_n;
  wire accept = req_valid && ready_reg;
  // a kept bus takes the new command on the same edge as setup starts
  wire next_write = accept ? is_write(req_cmd) : is_write(cmd_reg);
  // memory reads may close on the early acknowledge as well
  wire ack = !sy.xack_n || (cmd_reg == SBM_MEM_RD && !sy.aack_n);
  wire cmd_start = (state_reg == S_SETUP) && (setup_reg == '0) && (gap_reg == '0);
  wire cmd_active = (cmd_n_reg != 4'hf);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      S_IDLE: if (accept) state_next = S_REQ;
      // takeover only when the board says the bus is ours
      S_REQ: if (granted && !hold_n_reg) state_next = S_SETUP;
      S_OWN: if (accept) state_next = S_SETUP;
      S_SETUP: if (cmd_start) state_next = S_CMD;
      S_CMD: if (ack) state_next = S_DONE;
      S_DONE: state_next = last_reg ? S_IDLE : S_OWN;
      default: state_next = S_IDLE;
    endcase
    if (init_hit) state_next = S_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      bclk_d_reg <= 1'b1;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      bclk_d_reg <= sy.bclk_n;
      ready_reg <= (state_next == S_IDLE || state_next == S_OWN) && !accept && !init_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || init_hit) begin
      cmd_reg <= SBM_MEM_RD;
      last_reg <= 1'b1;
      adr_n_reg <= ADDR_IDLE;
      dat_n_reg <= DATA_IDLE;
    end else if (accept) begin
      cmd_reg <= req_cmd;
      last_reg <= req_last;
      adr_n_reg <= ~req_addr;
      dat_n_reg <= ~req_wdata;
    end
  end

  // the hold request is raised on a bus clock edge and dropped after the last byte
  always_ff @(posedge clk) begin
    if (!rst_n || init_hit) begin
      hold_n_reg <= 1'b1;
    end else if (state_reg == S_REQ && bclk_edge) begin
      hold_n_reg <= 1'b0;
    end else if (state_reg == S_DONE && last_reg) begin
      hold_n_reg <= 1'b1;
    end
  end

  // counters: settle time before a command, and byte rate spacing
  always_ff @(posedge clk) begin
    if (!rst_n || init_hit) begin
      setup_reg <= SETUP_CNT;
      gap_reg <= '0;
    end else begin
      setup_reg <= (state_next == S_SETUP && state_reg != S_SETUP) ? SETUP_CNT :
                   (setup_reg != '0 ? setup_reg - 1'b1 : setup_reg);
      gap_reg <= cmd_start ? BYTE_CNT : (gap_reg != '0 ? gap_reg - 1'b1 : gap_reg);
    end
  end

  // drivers stay on from setup until the command is released
  always_ff @(posedge clk) begin
    if (!rst_n || init_hit) begin
      adr_oe_reg <= 1'b0;
      dat_oe_reg <= 1'b0;
      cmd_n_reg <= 4'hf;
    end else begin
      adr_oe_reg <= (state_next == S_SETUP) || (state_next == S_CMD);
      dat_oe_reg <= ((state_next == S_SETUP) || (state_next == S_CMD)) && next_write;
      if (cmd_start) begin
        cmd_n_reg <= cmd_lines_n(cmd_reg);
      end else if (state_reg == S_CMD && ack) begin
        cmd_n_reg <= 4'hf;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || init_hit) begin
      rsp_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      rsp_reg <= (state_reg == S_CMD) && ack;
      if (state_reg == S_CMD && ack && !is_write(cmd_reg)) begin
        rdata_reg <= ~sy.dat_n;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign req_ready = ready_reg;
  assign rsp_valid = rsp_reg;
  assign rsp_rdata = rdata_reg;
  assign bus_owned = !hold_n_reg;
  assign hold_n = hold_n_reg;
  assign adr_n_o = adr_n_reg;
  assign adr_oe = adr_oe_reg;
  assign dat_n_o = dat_n_reg;
  assign dat_oe = dat_oe_reg;
  assign mrdc_n = cmd_n_reg[SBM_MEM_RD];
  assign mwtc_n = cmd_n_reg[SBM_MEM_WR];
  assign iorc_n = cmd_n_reg[SBM_IO_RD];
  assign iowc_n = cmd_n_reg[SBM_IO_WR];
  assign cmd_oe = adr_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_acked;
    (state_reg == S_CMD) && ack && !init_hit;
  endsequence

  sequence s_released;
    ((cmd_n_reg == 4'hf) && rsp_reg) ##1 !rsp_reg;
  endsequence

  cmd_one_hot_a: assert property ($onehot0(~cmd_n_reg))
    else $error("more than one command strobe active");
  cmd_granted_a: assert property (cmd_active |-> granted && !hold_n_reg)
    else $error("command driven without the bus");
  addr_stable_a: assert property (cmd_active && !ack && !init_hit |=> $stable(adr_n_reg) && $stable(dat_n_reg))
    else $error("address or data moved during command");
  ack_release_a: assert property (s_acked |=> s_released)
    else $error("command not released after acknowledge");
  aack_read_a: assert property (cmd_reg == SBM_MEM_RD && cmd_active && !sy.aack_n && !init_hit |=> !cmd_active)
    else $error("advance acknowledge ignored on memory read");
  byte_rate_a: assert property (cmd_start |=> !cmd_start [*3])
    else $error("commands closer than the byte rate allows");
  init_clear_a: assert property (init_hit |=> hold_n_reg && !cmd_active && !adr_oe_reg)
    else $error("init did not return master to idle");
  data_dir_a: assert property (cmd_active |-> adr_oe_reg && (dat_oe_reg == is_write(cmd_reg)))
    else $error("data driver direction wrong for command");
  hold_drop_a: assert property (state_reg == S_DONE && last_reg && !init_hit |=> hold_n_reg ##1 hold_n_reg)
    else $error("hold request kept after last transfer");
endmodule
`default_nettype wire

// file: bench/sbm_board_model.sv
// board and slave model on the far side of the bus master
`timescale 1ns/100ps
`default_nettype none
module sbm_board_model
  import sbm_pkg::*;
#(
  parameter int unsigned ACK_DLY_NS = 300
) (
  // board and slave pins
  output logic bclk_n,
  output logic takeover_granted_n,
  output logic xack_n,
  output logic aack_n,
  output logic [sbm_pkg::DATA_W-1:0] dat_n_i,
  // master pins
  input wire logic hold_n,
  input wire logic [sbm_pkg::ADDR_W-1:0] adr_n_o,
  input wire logic [sbm_pkg::DATA_W-1:0] dat_n_o,
  input wire logic dat_oe,
  input wire logic mrdc_n,
  input wire logic mwtc_n,
  input wire logic iorc_n,
  input wire logic iowc_n,
  input wire logic cmd_oe,
  // bench controls and observations
  input wire logic slow_ack,
  input wire logic use_aack,
  output logic [sbm_pkg::ADDR_W-1:0] seen_addr,
  output logic [sbm_pkg::DATA_W-1:0] seen_data,
  output int unsigned gap_ns,
  output int unsigned stab_errs
);
  import sbm_pkg::*;
  logic [7:0] mem [256];
  logic [7:0] drv_n;
  time t0;
  wire logic mem_rd = cmd_oe & ~mrdc_n;
  wire logic io_rd = cmd_oe & ~iorc_n;
  wire logic active = mem_rd | io_rd | (cmd_oe & ~mwtc_n) | (cmd_oe & ~iowc_n);
  // shared data wire: master wins while it drives
  assign dat_n_i = dat_oe ? dat_n_o : drv_n;
  assign #30 takeover_granted_n = hold_n;
  ////////////////////////////////////////////////////////////////////////////
  // free-running bus clock, phase unrelated to clk
  initial begin
    bclk_n = 1'b1;
    #37;
    forever #200 bclk_n = ~bclk_n;
  end
  initial begin
    xack_n = 1'b1;
    aack_n = 1'b1;
    drv_n = 8'h00;
    stab_errs = 0;
    t0 = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one slave cycle per command strobe
  always @(posedge active) begin
    gap_ns = int'($time - t0);
    t0 = $time;
    seen_addr = ~adr_n_o;
    #10;
    if (mem_rd) drv_n = ~mem[seen_addr[7:0]];
    // bench may also raise it on other commands, which must be ignored
    if (use_aack) aack_n = 1'b0;
    #((use_aack && mem_rd) ? 0 : (slow_ack ? 4 * ACK_DLY_NS : ACK_DLY_NS));
    if (io_rd) drv_n = ~(seen_addr[7:0] ^ 8'h5a);
    if (cmd_oe & ~mwtc_n) mem[seen_addr[7:0]] = ~dat_n_o;
    seen_data = ~dat_n_o;
    #20 xack_n = 1'b0;
    wait (!active);
    xack_n = 1'b1;
    aack_n = 1'b1;
    // released lines must not keep the last value
    drv_n = ~drv_n;
  end
  always @(adr_n_o, dat_n_o, dat_oe) begin
    if (active && xack_n) stab_errs++;
  end
endmodule
`default_nettype wire

// file: bench/sbm_master_tb_top.sv
// self-checking bench for the bus master
`timescale 1ns/100ps
`default_nettype none
module sbm_master_tb_top;
  import sbm_pkg::*;
  logic clk, rst_n, req_valid, req_last, init_n, slow_ack, use_aack;
  sbm_cmd_t req_cmd;
  logic [ADDR_W-1:0] req_addr, adr_n_o, seen_addr;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, dat_n_o, dat_n_i, seen_data;
  logic req_ready, rsp_valid, bus_owned, hold_n, adr_oe, dat_oe, cmd_oe;
  logic mrdc_n, mwtc_n, iorc_n, iowc_n, bclk_n, granted_n, xack_n, aack_n;
  int unsigned gap_ns, stab_errs;
  int n_errors, checks;
  sbm_master i_dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_last(req_last), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .bus_owned(bus_owned), .bclk_n(bclk_n),
    .init_n(init_n), .takeover_granted_n(granted_n), .xack_n(xack_n), .aack_n(aack_n),
    .dat_n_i(dat_n_i), .hold_n(hold_n), .adr_n_o(adr_n_o), .adr_oe(adr_oe),
    .dat_n_o(dat_n_o), .dat_oe(dat_oe), .mrdc_n(mrdc_n), .mwtc_n(mwtc_n),
    .iorc_n(iorc_n), .iowc_n(iowc_n), .cmd_oe(cmd_oe));
  sbm_board_model i_board (.bclk_n(bclk_n), .takeover_granted_n(granted_n), .xack_n(xack_n),
    .aack_n(aack_n), .dat_n_i(dat_n_i), .hold_n(hold_n), .adr_n_o(adr_n_o),
    .dat_n_o(dat_n_o), .dat_oe(dat_oe), .mrdc_n(mrdc_n), .mwtc_n(mwtc_n),
    .iorc_n(iorc_n), .iowc_n(iowc_n), .cmd_oe(cmd_oe), .slow_ack(slow_ack),
    .use_aack(use_aack), .seen_addr(seen_addr), .seen_data(seen_data), .gap_ns(gap_ns),
    .stab_errs(stab_errs));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stuck(input string what);
    n_errors++;
    $display("BAD %s expected done seen stuck", what);
    final_report();
  endtask
  // called at a falling edge; returns at the falling edge of the answer
  task automatic xfer(input sbm_cmd_t c, input logic [15:0] a, input logic [7:0] d,
    input logic l);
    int i;
    req_cmd = c;
    req_addr = a;
    req_wdata = d;
    req_last = l;
    req_valid = 1'b1;
    for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk);
    if (i == 100) stuck("req_ready");
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 400 && rsp_valid !== 1'b1; i++) @(negedge clk);
    if (i == 400) stuck("rsp_valid");
  endtask
  task automatic wait_hold;
    int i;
    for (i = 0; i < 20 && hold_n !== 1'b1; i++) @(negedge clk);
    check("hold_n off", hold_n, 1'b1);
    if (i == 20) stuck("hold_n");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // write then read back on a kept bus; top address bit, slow ack, advance ack
  task automatic t_mem;
    logic [15:0] a [2] = '{16'h0001, 16'h8000};
    logic [7:0] d;
    for (int k = 0; k < 2; k++) begin
      d = 8'h3c + 8'(k);
      slow_ack = (k == 0);
      xfer(SBM_MEM_WR, a[k], d, 1'b0);
      check("wr addr", seen_addr, a[k]);
      check("wr data", seen_data, d);
      check("bus kept", bus_owned, 1'b1);
      use_aack = (k == 1);
      xfer(SBM_MEM_RD, a[k], 8'h00, 1'b1);
      check("rd data", rsp_rdata, d);
      check("cmd gap", gap_ns >= 200, 1'b1);
      use_aack = 1'b0;
      wait_hold();
    end
    slow_ack = 1'b0;
  endtask
  // advance ack offered on I/O too, where it must not end the read
  task automatic t_io;
    xfer(SBM_IO_WR, 16'h00e5, 8'h96, 1'b0);
    check("io wr addr", seen_addr, 16'h00e5);
    check("io wr data", seen_data, 8'h96);
    use_aack = 1'b1;
    xfer(SBM_IO_RD, 16'h00e4, 8'h00, 1'b1);
    check("io rd data", rsp_rdata, 8'he4 ^ 8'h5a);
    use_aack = 1'b0;
    wait_hold();
  endtask
  task automatic t_init;
    xfer(SBM_MEM_WR, 16'h0040, 8'ha5, 1'b0);
    check("owned", bus_owned, 1'b1);
    init_n = 1'b0;
    wait_hold();
    check("init owned", bus_owned, 1'b0);
    check("init ready", req_ready, 1'b0);
    check("init adr_oe", adr_oe, 1'b0);
    init_n = 1'b1;
    xfer(SBM_MEM_RD, 16'h0040, 8'h00, 1'b1);
    check("after init", rsp_rdata, 8'ha5);
    wait_hold();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    n_errors = 0;
    checks = 0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_cmd = SBM_MEM_RD;
    req_addr = 16'h0000;
    req_wdata = 8'h00;
    req_last = 1'b1;
    init_n = 1'b1;
    slow_ack = 1'b0;
    use_aack = 1'b0;
    repeat (5) @(negedge clk);
    check("rst hold_n", hold_n, 1'b1);
    check("rst cmd_oe", cmd_oe, 1'b0);
    rst_n = 1'b1;
    t_mem();
    t_io();
    t_init();
    check("stable", stab_errs, 0);
    final_report();
  end
endmodule
`default_nettype wire
